//--- dhbi_host_bus_interface.sv
// host bus interface of a dual serial controller: bus cycles, vector, reset effects
//
// Functional notes
// - select low: transfer bytes per direction, address
// - select and interrupt acknowledge high: data lines undriven
// - address picks register; device routes access
// - eight-bit bus, bit zero least significant
// - reset clears status, mask, port registers
// - reset loads vector register with 0F
// - reset drives output pins high, halts timer
// - reset idles channels, serial outputs mark
// - reset cancels test, mode pointer first
// - acknowledge every read and write cycle; vector cycle only with pending
// - interrupt request low when masked condition true
// - vector cycle with pending: drive vector, acknowledge
`timescale 1ns/10ps
`default_nettype none
`include "dhbi_regs.svh"

module dhbi_host_bus_interface
    import dhbi_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chip_select_n,
    input wire logic read_write_dir,
    input wire logic interrupt_ack_n,
    input wire logic [3:0] register_address,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    output logic transfer_ack_n,
    output logic transfer_ack_oe,
    output logic interrupt_request_n,
    output logic interrupt_request_oe,
    output logic [7:0] general_output_pins,
    output logic chan_a_serial_out,
    output logic chan_b_serial_out,
    output logic timer_running,
    output logic test_mode,
    output logic mode_ptr_a,
    output logic mode_ptr_b
);

    localparam int ACK_CYC = `DHBI_ACK_HOLD_CYC;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: the host runs on its own timing
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [7:0] data_s1;
    logic [7:0] data_s2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 7'h7F;
            sync2 <= 7'h7F;
            data_s1 <= 8'h00;
            data_s2 <= 8'h00;
        end else if (clk_en) begin
            sync1 <= {chip_select_n, read_write_dir, interrupt_ack_n, register_address};
            sync2 <= sync1;
            data_s1 <= host_data_in;
            data_s2 <= data_s1;
        end
    end

    dhbi_host_req_t req;
    always_comb begin
        req.sel = ~sync2[6];
        req.rd = sync2[5];
        req.iack = ~sync2[4];
        req.addr = sync2[3:0];
        req.data = data_s2;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers touched by the host or by reset
    logic [7:0] stat_a;
    logic [7:0] stat_b;
    logic [7:0] interrupt_mask_register;
    logic [7:0] interrupt_status_register;
    logic [7:0] output_port_register;
    logic [7:0] output_port_config_register;
    logic [7:0] interrupt_vector_register;
    logic [7:0] ev_set;
    logic [7:0] ev_clr;
    logic [1:0] ctrl;
    logic irq_pending;
    dhbi_state_t state;
    logic [3:0] ack_cnt;
    logic do_write;
    logic cycle_start;

    assign irq_pending = |(interrupt_status_register & interrupt_mask_register);
    assign cycle_start = (state == DHBI_IDLE) && (req.sel || req.iack);
    assign do_write = cycle_start && req.sel && !req.rd && !req.iack;

    // host register writes, address decoded to the register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_mask_register <= `DHBI_RST_ZERO;
            output_port_config_register <= `DHBI_RST_ZERO;
            interrupt_vector_register <= `DHBI_RST_IVR;
            output_port_register <= `DHBI_RST_ZERO;
        end else if (clk_en && do_write) begin
            unique case (req.addr)
                `DHBI_ADDR_IMR: interrupt_mask_register <= req.data;
                `DHBI_ADDR_OUTPUT_PORT_CONFIG_REGISTER: output_port_config_register <= req.data;
                `DHBI_ADDR_IVR: interrupt_vector_register <= req.data;
                `DHBI_ADDR_OP_SET: output_port_register <= output_port_register | req.data;
                `DHBI_ADDR_OP_CLR: output_port_register <= output_port_register & ~req.data;
                default: ;
            endcase
        end
    end

    // status bits: events from software set them, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_status_register <= `DHBI_RST_ZERO;
            stat_a <= `DHBI_RST_ZERO;
            stat_b <= `DHBI_RST_ZERO;
        end else if (clk_en) begin
            interrupt_status_register <= (interrupt_status_register & ~ev_clr) | ev_set;
        end
    end

    // mode pointers step on mode-register access; reset aims them at the first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ptr_a <= 1'b0;
            mode_ptr_b <= 1'b0;
        end else if (clk_en && cycle_start && req.sel && !req.iack) begin
            if (req.addr == `DHBI_ADDR_MODE_A) begin
                mode_ptr_a <= 1'b1;
            end
            if (req.addr == `DHBI_ADDR_MODE_B) begin
                mode_ptr_b <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cycle state machine: one acknowledge per select or pending vector cycle, then wait for release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= DHBI_IDLE;
            ack_cnt <= 4'h0;
        end else if (clk_en) begin
            unique case (state)
                DHBI_IDLE: begin
                    if (req.sel || (req.iack && irq_pending)) begin
                        state <= DHBI_ACK;
                        ack_cnt <= 4'(ACK_CYC);
                    end else if (req.iack) begin
                        state <= DHBI_WAIT_END;
                    end
                end
                DHBI_ACK: begin
                    // acknowledge stays until the host drops the cycle
                    if (ack_cnt != 4'h0) begin
                        ack_cnt <= ack_cnt - 4'h1;
                    end
                    if (!req.sel && !req.iack) begin
                        state <= DHBI_IDLE;
                    end
                end
                DHBI_WAIT_END: begin
                    if (!req.sel && !req.iack) begin
                        state <= DHBI_IDLE;
                    end
                end
            endcase
        end
    end

    // read mux: decode address to the register
    logic [7:0] rd_val;
    always_comb begin
        rd_val = 8'h00;
        unique case (req.addr)
            `DHBI_ADDR_STAT_A: rd_val = stat_a;
            `DHBI_ADDR_ISR: rd_val = interrupt_status_register;
            `DHBI_ADDR_STAT_B: rd_val = stat_b;
            `DHBI_ADDR_IVR: rd_val = interrupt_vector_register;
            `DHBI_ADDR_OUTPUT_PORT_CONFIG_REGISTER: rd_val = output_port_config_register;
            default: rd_val = 8'h00;
        endcase
    end

    // bus drivers, all from flip-flops; data released when select and interrupt acknowledge are high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_data_out <= 8'h00;
            host_data_oe <= 1'b0;
            transfer_ack_n <= 1'b1;
            transfer_ack_oe <= 1'b0;
        end else if (clk_en) begin
            if (state == DHBI_IDLE && req.iack && irq_pending) begin
                host_data_out <= interrupt_vector_register;
                host_data_oe <= 1'b1;
                transfer_ack_n <= 1'b0;
                transfer_ack_oe <= 1'b1;
            end else if (state == DHBI_IDLE && req.sel) begin
                host_data_out <= rd_val;
                host_data_oe <= req.rd;
                transfer_ack_n <= 1'b0;
                transfer_ack_oe <= 1'b1;
            end else if (!req.sel && !req.iack) begin
                host_data_oe <= 1'b0;
                transfer_ack_n <= 1'b1;
                transfer_ack_oe <= 1'b0;
            end
        end
    end

    // open-drain interrupt line: enable pulls low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_request_n <= 1'b1;
            interrupt_request_oe <= 1'b0;
        end else if (clk_en) begin
            interrupt_request_n <= ~irq_pending;
            interrupt_request_oe <= irq_pending;
        end
    end

    // output pins show the inverted port register; reset makes them high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            general_output_pins <= `DHBI_RST_OUT_PINS;
            chan_a_serial_out <= 1'b1;
            chan_b_serial_out <= 1'b1;
        end else if (clk_en) begin
            general_output_pins <= ~output_port_register;
            chan_a_serial_out <= 1'b1;
            chan_b_serial_out <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave: control bits, status view, event injection; zero wait
    logic apb_hit;
    assign apb_hit = psel && penable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 2'b00;
            ev_set <= 8'h00;
            ev_clr <= 8'h00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            ev_set <= 8'h00;
            ev_clr <= 8'h00;
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pslverr <= !(paddr == `DHBI_APB_CTRL || paddr == `DHBI_APB_STATUS
                    || paddr == `DHBI_APB_EVENTS);
                unique case (paddr)
                    `DHBI_APB_CTRL: prdata <= {30'h0, ctrl};
                    `DHBI_APB_STATUS: prdata <= {8'h00, interrupt_vector_register, interrupt_mask_register, interrupt_status_register};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
            // writes land only at the edge that completes the access phase
            if (apb_hit && pready && pwrite && paddr == `DHBI_APB_CTRL) begin
                ctrl <= pwdata[1:0];
            end
            if (apb_hit && pready && pwrite && paddr == `DHBI_APB_EVENTS) begin
                ev_set <= pwdata[7:0];
                ev_clr <= pwdata[15:8];
            end
        end
    end

    // test mode and timer run flags follow control; reset cancels both
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_mode <= 1'b0;
            timer_running <= 1'b0;
        end else if (clk_en) begin
            test_mode <= ctrl[`DHBI_CTRL_TEST_BIT];
            timer_running <= ctrl[`DHBI_CTRL_TIMER_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_idle_release;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && state == DHBI_IDLE && !req.sel && !req.iack) |=> !host_data_oe;
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("data driven while idle");

    property p_ack_on_sel;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && state == DHBI_IDLE && req.sel) |=> (!transfer_ack_n && transfer_ack_oe);
    endproperty
    a_ack_on_sel: assert property (p_ack_on_sel) else $error("no acknowledge");

    property p_vector;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && state == DHBI_IDLE && req.iack && !req.sel && irq_pending)
            |=> (host_data_oe && host_data_out == $past(interrupt_vector_register));
    endproperty
    a_vector: assert property (p_vector) else $error("vector missing");

    property p_no_vector;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && state == DHBI_IDLE && req.iack && !req.sel && !irq_pending)
            |=> !transfer_ack_oe;
    endproperty
    a_no_vector: assert property (p_no_vector) else $error("spurious acknowledge");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        clk_en |=> (interrupt_request_oe == $past(irq_pending));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt line wrong");

    property p_write_dir;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && do_write && req.addr == `DHBI_ADDR_IVR) |=> interrupt_vector_register == $past(req.data);
    endproperty
    a_write_dir: assert property (p_write_dir) else $error("write lost");

    property p_read_dir;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && state == DHBI_IDLE && req.sel && !req.iack) |=> host_data_oe == $past(req.rd);
    endproperty
    a_read_dir: assert property (p_read_dir) else $error("direction wrong");

    property p_pins;
        @(posedge pclk) disable iff (!presetn)
        clk_en |=> general_output_pins == ~$past(output_port_register);
    endproperty
    a_pins: assert property (p_pins) else $error("output pins wrong");

endmodule
`default_nettype wire

//--- dhbi_host_model.sv
// host processor model that runs select and acknowledge cycles on the byte bus
`timescale 1ns/10ps
`default_nettype none

module dhbi_host_model (
    input wire logic pclk,
    output logic chip_select_n,
    output logic read_write_dir,
    output logic interrupt_ack_n,
    output logic [3:0] register_address,
    output logic [7:0] host_drv,
    input wire logic [7:0] bus_data,
    input wire logic transfer_ack_n,
    input wire logic transfer_ack_oe
);

    // idle bus: nothing selected
    initial begin
        chip_select_n = 1'h1;
        read_write_dir = 1'h1;
        interrupt_ack_n = 1'h1;
        register_address = 4'h0;
        host_drv = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one byte cycle; pins stay put until acknowledge or 16 cycles, since the device samples late
    task automatic cycle(input logic rd, input logic iack, input logic [3:0] addr,
                         input logic [7:0] wd, output logic [7:0] rdat, output logic acked);
        int n;
        begin
            @(posedge pclk);
            chip_select_n <= iack;
            interrupt_ack_n <= !iack;
            read_write_dir <= rd | iack;
            register_address <= addr;
            host_drv <= rd ? ~host_drv : wd;
            acked = 1'h0;
            rdat = 8'h00;
            for (n = 0; n < 16 && !acked; n++) begin
                @(posedge pclk);
                if (transfer_ack_oe === 1'h1 && transfer_ack_n === 1'h0) begin
                    acked = 1'h1;
                    rdat = bus_data;
                end
            end
            // release after the acknowledge edge or the 16-cycle timeout; stale data is scrambled
            chip_select_n <= 1'h1;
            interrupt_ack_n <= 1'h1;
            host_drv <= ~host_drv;
            for (n = 0; n < 12 && transfer_ack_oe !== 1'h0; n++) begin
                @(posedge pclk);
            end
            repeat (2) @(posedge pclk);
        end
    endtask

endmodule

`default_nettype wire

//--- dhbi_pkg.sv
// types shared by the host bus interface
package dhbi_pkg;
    typedef enum logic [1:0] {
        DHBI_IDLE,
        DHBI_ACK,
        DHBI_WAIT_END
    } dhbi_state_t;

    typedef struct packed {
        logic sel;
        logic rd;
        logic iack;
        logic [3:0] addr;
        logic [7:0] data;
    } dhbi_host_req_t;
endpackage

//--- dhbi_regs.svh
// register offsets, reset values and timing counts of the host bus interface
`ifndef DHBI_REGS_SVH
`define DHBI_REGS_SVH

// clock rate and acknowledge timing
`define DHBI_CLK_MHZ 25
`define DHBI_ACK_HOLD_NS 80
`define DHBI_ACK_HOLD_CYC ((`DHBI_ACK_HOLD_NS * `DHBI_CLK_MHZ + 999) / 1000)

// register indices on the four address lines
`define DHBI_ADDR_MODE_A 4'h0
`define DHBI_ADDR_STAT_A 4'h1
`define DHBI_ADDR_ISR 4'h5
`define DHBI_ADDR_IMR 4'h5
`define DHBI_ADDR_MODE_B 4'h8
`define DHBI_ADDR_STAT_B 4'h9
`define DHBI_ADDR_IVR 4'hC
`define DHBI_ADDR_OUTPUT_PORT_CONFIG_REGISTER 4'hD
`define DHBI_ADDR_OP_SET 4'hE
`define DHBI_ADDR_OP_CLR 4'hF
`define DHBI_ADDR_IRQ_SRC 4'h2

// reset values
`define DHBI_RST_IVR 8'h0F
`define DHBI_RST_ZERO 8'h00
`define DHBI_RST_OUT_PINS 8'hFF

// apb register offsets for the control path
`define DHBI_APB_CTRL 12'h000
`define DHBI_APB_STATUS 12'h004
`define DHBI_APB_EVENTS 12'h008

// field positions
`define DHBI_CTRL_TEST_BIT 0
`define DHBI_CTRL_TIMER_BIT 1

`endif

//--- tb_top.sv
// self-checking bench: apb control path, host byte cycles and reset effects
`timescale 1ns/10ps
`default_nettype none
`include "dhbi_regs.svh"

module tb_top;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd32;
    logic chip_select_n, read_write_dir, interrupt_ack_n, host_data_oe, ok, err;
    logic transfer_ack_n, transfer_ack_oe, interrupt_request_n, interrupt_request_oe;
    logic [3:0] register_address;
    logic [7:0] host_drv, host_data_out, bus_data, general_output_pins, rd8;
    logic chan_a_serial_out, chan_b_serial_out, timer_running, test_mode;
    logic mode_ptr_a, mode_ptr_b, irq_line;
    int miscompares = 0;
    int n_compared = 0;

    // wire levels: device wins the data bus when enabled; request line has a pull-up
    assign bus_data = host_data_oe ? host_data_out : host_drv;
    assign irq_line = interrupt_request_oe ? interrupt_request_n : 1'h1;

    dhbi_host_bus_interface u_dhbi_host_bus_interface (
        .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .chip_select_n, .read_write_dir, .interrupt_ack_n,
        .register_address, .host_data_in(bus_data), .host_data_out, .host_data_oe,
        .transfer_ack_n, .transfer_ack_oe, .interrupt_request_n, .interrupt_request_oe,
        .general_output_pins, .chan_a_serial_out, .chan_b_serial_out, .timer_running,
        .test_mode, .mode_ptr_a, .mode_ptr_b);

    dhbi_host_model u_dhbi_host_model (
        .pclk, .chip_select_n, .read_write_dir, .interrupt_ack_n, .register_address,
        .host_drv, .bus_data, .transfer_ack_n, .transfer_ack_oe);

    // 25 MHz clock
    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            n_compared++;
            if (got !== exp) begin
                miscompares++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // apb transfer; held until pready, then released
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        begin
            @(posedge pclk);
            psel <= 1'h1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= wd;
            @(posedge pclk);
            penable <= 1'h1;
            // no wait count assumed: only the watchdog ends a hung access
            do begin
                @(posedge pclk);
            end while (pready !== 1'h1);
            chk(32'(pready), 32'h1);
            rd32 = prdata;
            err = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
        end
    endtask

    task automatic hc(input logic rd, input logic iack, input logic [3:0] a, input logic [7:0] wd);
        u_dhbi_host_model.cycle(rd, iack, a, wd, rd8, ok);
    endtask

    // reset held 4 cycles; the pin synchronisers need a few edges after it
    task automatic do_reset;
        begin
            presetn <= 1'h0;
            repeat (4) @(posedge pclk);
            presetn <= 1'h1;
            repeat (3) @(posedge pclk);
        end
    endtask

    task automatic rst_chk;
        begin
            chk(32'(general_output_pins), 32'hFF);
            chk(32'({chan_a_serial_out, chan_b_serial_out}), 32'h3);
            chk(32'({timer_running, test_mode, mode_ptr_a, mode_ptr_b}), 32'h0);
            chk(32'({host_data_oe, transfer_ack_oe, irq_line}), 32'h1);
            apb(1'h0, `DHBI_APB_STATUS, 32'h0);
            chk(rd32, 32'h000F0000);
            hc(1'h1, 1'h0, `DHBI_ADDR_STAT_A, 8'h00);
            chk(32'({ok, rd8}), 32'h100);
            hc(1'h1, 1'h0, `DHBI_ADDR_STAT_B, 8'h00);
            chk(32'({ok, rd8}), 32'h100);
            hc(1'h1, 1'h0, `DHBI_ADDR_OUTPUT_PORT_CONFIG_REGISTER, 8'h00);
            chk(32'({ok, rd8}), 32'h100);
        end
    endtask

    task automatic test_done;
        begin
            $display("compared %0d mismatches %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        repeat (8000) @(posedge pclk);
        miscompares++;
        test_done;
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        clk_en = 1'h1;
        do_reset;
        rst_chk;
        apb(1'h1, `DHBI_APB_CTRL, 32'h3);
        apb(1'h0, 12'h010, 32'h0);
        chk(32'({err, timer_running, test_mode}), 32'h7);
        // byte routing, bit order and acknowledge
        hc(1'h0, 1'h0, `DHBI_ADDR_IVR, 8'hA5);
        chk(32'(ok), 32'h1);
        hc(1'h1, 1'h0, `DHBI_ADDR_IVR, 8'h00);
        chk(32'({ok, rd8}), 32'h1A5);
        hc(1'h0, 1'h0, `DHBI_ADDR_OUTPUT_PORT_CONFIG_REGISTER, 8'h5A);
        hc(1'h1, 1'h0, `DHBI_ADDR_OUTPUT_PORT_CONFIG_REGISTER, 8'h00);
        chk(32'({ok, rd8}), 32'h15A);
        hc(1'h0, 1'h0, `DHBI_ADDR_MODE_A, 8'h13);
        chk(32'(mode_ptr_a), 32'h1);
        hc(1'h0, 1'h0, `DHBI_ADDR_MODE_B, 8'h13);
        chk(32'({mode_ptr_a, mode_ptr_b}), 32'h3);
        hc(1'h0, 1'h0, `DHBI_ADDR_OP_SET, 8'h0F);
        hc(1'h0, 1'h0, `DHBI_ADDR_OP_CLR, 8'h03);
        chk(32'(general_output_pins), 32'hF3);
        // enable low freezes everything: a host cycle goes unseen
        clk_en <= 1'h0;
        hc(1'h0, 1'h0, `DHBI_ADDR_OP_SET, 8'hF0);
        chk(32'({ok, general_output_pins}), 32'h0F3);
        clk_en <= 1'h1;
        // masked condition raises the request and enables the vector
        hc(1'h0, 1'h0, `DHBI_ADDR_IMR, 8'h81);
        apb(1'h1, `DHBI_APB_EVENTS, 32'h1);
        repeat (3) @(posedge pclk);
        chk(32'(irq_line), 32'h0);
        apb(1'h0, `DHBI_APB_STATUS, 32'h0);
        chk(rd32, 32'h00A58101);
        hc(1'h1, 1'h0, `DHBI_ADDR_ISR, 8'h00);
        chk(32'(rd8), 32'h01);
        hc(1'h1, 1'h1, 4'h0, 8'h00);
        chk(32'({ok, rd8}), 32'h1A5);
        // only an unmasked condition left: no request, vector cycle ignored
        apb(1'h1, `DHBI_APB_EVENTS, 32'h0104);
        repeat (3) @(posedge pclk);
        chk(32'(irq_line), 32'h1);
        hc(1'h1, 1'h1, 4'h0, 8'h00);
        chk(32'({ok, host_data_oe, transfer_ack_oe}), 32'h0);
        apb(1'h1, `DHBI_APB_CTRL, 32'h3);
        // second reset in mid-run undoes everything above
        do_reset;
        rst_chk;
        test_done;
    end

endmodule

`default_nettype wire
